// ### hw/pss_pkg.sv
// Purpose : shared constants for the pattern shift sequencer
// Assumes : 200 MHz system clock
// Notes   : timing counts derive from printed times and the clock rate
package pss_pkg;

    // ==========================================================
    // geometry and bus selector codes
    localparam int          STAGES       = 16;
    localparam int          HALF         = 8;
    localparam int          BUSES        = 3;
    localparam logic [1:0]  BUS_SEL_1    = 2'h0;
    localparam logic [1:0]  BUS_SEL_2    = 2'h1;
    localparam logic [1:0]  BUS_SEL_3    = 2'h2;

    // ==========================================================
    // timing
    localparam int          CLK_HZ       = 200_000_000;
    localparam int          TRIG_US      = 1000;
    localparam int          TRIG_CYCLES  = (CLK_HZ / 1_000_000) * TRIG_US;
    localparam int          DEBOUNCE_US  = 5000;
    localparam int          DEB_CYCLES   = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int          CNT_W        = 24;

    // ==========================================================
    // reset values
    localparam logic [15:0] STAGE_RST    = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

endpackage : pss_pkg

// ### hw/pss_sequencer.sv
// Purpose : sixteen-stage recirculating pattern register with gate buses
// Assumes : all switch inputs are static levels; pins are asynchronous
// Notes   : analog voltage, glide and range circuits are not modelled
// Notes   : buttons are debounced, jack inputs pass two sync flops
`timescale 1ns/1ps
`default_nettype none

// How it works
// - split mode: stages 1-8 recirculate alone
// - split mode: stages 9-16 recirculate alone
// - enable low freezes all stages on clocks
// - manual load copies switches into stages
// - split mode: invert option feeds stage 16 inverse to 9
// - manual step advances once regardless of enable
// - each stage routed to bus; bus active if set
// - master gate pulses when any bus active
// - merge holds bus high across active steps
// - bus-1 reload reloads at bus-1 stage
// - external load edge reloads, restart step one
// - external load ignored when disabled
// - random mode loads stage 1 from comparator
// - random bits shift through stages 1-16, 1-8 if split
// - random indicator follows the comparator
// - every bus trigger gives 1 ms pulse
// - gate output high while clock high, active
// - full mode: one sixteen-stage ring
module pss_sequencer #(
    parameter int TRIG_COUNT = pss_pkg::TRIG_CYCLES,
    parameter int DEB_COUNT  = pss_pkg::DEB_CYCLES
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ext_clock_in,
    input  wire logic        ext_load_in,
    input  wire logic        random_cmp_in,
    input  wire logic        load_button_in,
    input  wire logic        step_button_in,
    input  wire logic [15:0] pattern_switch_in,
    input  wire logic [31:0] bus_select_in,
    input  wire logic [2:0]  merge_enable_in,
    input  wire logic        split_ring_select_in,
    input  wire logic        invert_second_in,
    input  wire logic        clock_enable_in,
    input  wire logic        bus1_reload_in,
    input  wire logic        ext_load_enable_in,
    input  wire logic        random_mode_in,
    output logic      [15:0] stage_out,
    output logic      [2:0]  bus_gate_out,
    output logic             master_gate_out,
    output logic      [2:0]  bus_trig_out,
    output logic             master_trig_out,
    output logic             clock_led_out,
    output logic             random_led_out
);

    // counter width shared by the debounce and trigger timers
    localparam int CW = pss_pkg::CNT_W;

    // ==========================================================
    // elaboration checks
    initial
    begin
        if (TRIG_COUNT < 1 || TRIG_COUNT >= (1 << CW))
            $error("trigger count out of range");
        if (DEB_COUNT < 1 || DEB_COUNT >= (1 << CW))
            $error("debounce count out of range");
        if (pss_pkg::HALF * 2 != pss_pkg::STAGES)
            $error("ring halves must tile the register");
        if (pss_pkg::BUSES != 3)
            $error("bus decode serves three buses only");
    end

    // ==========================================================
    // all state in one struct: sync chains, debounce, ring, buses
    typedef struct packed {
        logic [2:0]    sync1;     // first sync stage: clk, load, cmp
        logic [2:0]    sync2;     // second sync stage
        logic [2:0]    sync_d;    // delayed for edge detection
        logic [1:0]    btn1;      // button first sync stage
        logic [1:0]    btn2;      // button second sync stage
        logic [1:0]    btn_st;    // debounced button level
        logic [CW-1:0] deb0;
        logic [CW-1:0] deb1;
        logic [15:0]   stages;
        logic [3:0]    bus_act;   // master, 3, 2, 1 activity latched
        logic [CW-1:0] trig0;
        logic [CW-1:0] trig1;
        logic [CW-1:0] trig2;
        logic [CW-1:0] trigm;
        logic [2:0]    gate;
        logic          mgate;
        logic          cmp;
    } pss_state_s;

    pss_state_s st_reg;
    pss_state_s st_next;

    logic [15:0] shifted;
    logic [3:0]  act_now;
    logic        clk_rise;
    logic        clk_lvl;
    logic        load_rise;
    logic        load_press;
    logic        step_press;
    logic        fb1;
    logic        fb9;
    logic        hit_bus1;
    logic [15:0] stage_bus1;

    // ==========================================================
    // per-stage bus decode
    // bus-1 membership per stage, used only by the reload test
    genvar gi;
    generate
        for (gi = 0; gi < pss_pkg::STAGES; gi++)
        begin : g_dec
            assign stage_bus1[gi] = (bus_select_in[2*gi +: 2] == pss_pkg::BUS_SEL_1);
        end
    endgenerate

    // ==========================================================
    // bus activity from stage contents and routing
    // selector code 3 leaves a stage off every bus
    always_comb
    begin
        act_now = 4'h0;
        for (int i = 0; i < pss_pkg::STAGES; i++)
        begin
            if (st_reg.stages[i])
            begin
                if (bus_select_in[2*i +: 2] == pss_pkg::BUS_SEL_1)
                    act_now[0] = 1'b1;
                else if (bus_select_in[2*i +: 2] == pss_pkg::BUS_SEL_2)
                    act_now[1] = 1'b1;
                else if (bus_select_in[2*i +: 2] == pss_pkg::BUS_SEL_3)
                    act_now[2] = 1'b1;
            end
        end
        act_now[3] = |act_now[2:0];
    end

    // ==========================================================
    // ring feedback and shift
    // stage k sits in bit k-1; split mode breaks the chain at 8/9
    // and closes each half on itself; random mode replaces only
    // the stage 1 feed, so in split mode the second half keeps its own ring
    always_comb
    begin
        if (random_mode_in)
            fb1 = st_reg.cmp;
        else if (split_ring_select_in)
            fb1 = st_reg.stages[7];
        else
            fb1 = st_reg.stages[15];
        if (split_ring_select_in)
            fb9 = invert_second_in ? ~st_reg.stages[15]
                                   : st_reg.stages[15];
        else
            fb9 = st_reg.stages[7];
        shifted = {st_reg.stages[14:8], fb9, st_reg.stages[6:0], fb1};
    end

    // ==========================================================
    // input edges and presses
    assign clk_lvl    = st_reg.sync2[0];
    assign clk_rise   = st_reg.sync2[0] & ~st_reg.sync_d[0];
    assign load_rise  = st_reg.sync2[1] & ~st_reg.sync_d[1] & ext_load_enable_in;
    // one clock edge per pin rise, seen after the two sync flops
    // reload is judged on where the bits would land, not where they are
    assign hit_bus1   = bus1_reload_in && |(shifted & stage_bus1);

    // ==========================================================
    // next-state logic
    always_comb
    begin
        st_next        = st_reg;
        st_next.sync1  = {random_cmp_in, ext_load_in, ext_clock_in};
        st_next.sync2  = st_reg.sync1;
        st_next.sync_d = st_reg.sync2;
        st_next.cmp    = st_reg.sync2[2];
        st_next.btn1   = {step_button_in, load_button_in};
        st_next.btn2   = st_reg.btn1;
        // pins pass two flops before any edge or level is read
        // debounce: level must differ for the whole count to flip;
        // the long count trades button feel for immunity to bounce
        if (st_reg.btn2[0] == st_reg.btn_st[0])
        begin
            st_next.deb0 = pss_pkg::CNT_RST;
        end
        else if (st_reg.deb0 == CW'(DEB_COUNT - 1))
        begin
            st_next.deb0      = pss_pkg::CNT_RST;
            st_next.btn_st[0] = st_reg.btn2[0];
        end
        else
        begin
            st_next.deb0 = st_reg.deb0 + 1'b1;
        end
        if (st_reg.btn2[1] == st_reg.btn_st[1])
        begin
            st_next.deb1 = pss_pkg::CNT_RST;
        end
        else if (st_reg.deb1 == CW'(DEB_COUNT - 1))
        begin
            st_next.deb1      = pss_pkg::CNT_RST;
            st_next.btn_st[1] = st_reg.btn2[1];
        end
        else
        begin
            st_next.deb1 = st_reg.deb1 + 1'b1;
        end

        // a press is the debounced level rising; read from the next
        // value so the action lands on the edge the level flips
        load_press = !st_reg.btn_st[0] && st_next.btn_st[0];
        step_press = !st_reg.btn_st[1] && st_next.btn_st[1];

        // stage update: load beats step beats clock; a load that meets
        // a clock edge wins so the pattern restarts cleanly at step one
        if (load_press || load_rise)
            st_next.stages = pattern_switch_in;
        else if (step_press)
            st_next.stages = shifted;
        else if (clk_rise && clock_enable_in)
        begin
            if (hit_bus1)
                st_next.stages = pattern_switch_in;
            else
                st_next.stages = shifted;
        end

        // activity latched at clock rise so gates follow the step;
        // freezing clears it so no gate hangs high while clocks are ignored
        if (clk_rise && clock_enable_in)
            st_next.bus_act = act_now;
        else if (!clock_enable_in)
            st_next.bus_act = 4'h0;

        // gates: clock high during active step, merged buses hold
        // merge hides the clock level, the master never merges
        for (int b = 0; b < pss_pkg::BUSES; b++)
        begin
            st_next.gate[b] = st_next.bus_act[b] &
                              (st_reg.sync2[0] | merge_enable_in[b]);
        end
        st_next.mgate = st_next.bus_act[3] & st_reg.sync2[0];

        // trigger counters restart on each gate rise; a rise during a
        // running pulse restarts it rather than adding a second one
        if (st_next.gate[0] && !st_reg.gate[0])
            st_next.trig0 = CW'(TRIG_COUNT);
        else if (st_reg.trig0 != pss_pkg::CNT_RST)
            st_next.trig0 = st_reg.trig0 - 1'b1;
        if (st_next.gate[1] && !st_reg.gate[1])
            st_next.trig1 = CW'(TRIG_COUNT);
        else if (st_reg.trig1 != pss_pkg::CNT_RST)
            st_next.trig1 = st_reg.trig1 - 1'b1;
        if (st_next.gate[2] && !st_reg.gate[2])
            st_next.trig2 = CW'(TRIG_COUNT);
        else if (st_reg.trig2 != pss_pkg::CNT_RST)
            st_next.trig2 = st_reg.trig2 - 1'b1;
        if (st_next.mgate && !st_reg.mgate)
            st_next.trigm = CW'(TRIG_COUNT);
        else if (st_reg.trigm != pss_pkg::CNT_RST)
            st_next.trigm = st_reg.trigm - 1'b1;
    end

    // ==========================================================
    // state register; stages cleared at reset, operator loads anyway
    // synchronous reset only, so every flop sees one clean edge
    // and no reset path races the pin synchronisers
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            st_reg        <= '0;
            st_reg.stages <= pss_pkg::STAGE_RST;
        end
        else
            st_reg <= st_next;
    end

    // ==========================================================
    // outputs from flip-flops; trigger outputs decode their counters
    assign stage_out       = st_reg.stages;
    assign bus_gate_out    = st_reg.gate;
    assign master_gate_out = st_reg.mgate;
    // trigger is high while its counter runs, so width is exact
    assign bus_trig_out[0] = st_reg.trig0 != pss_pkg::CNT_RST;
    assign bus_trig_out[1] = st_reg.trig1 != pss_pkg::CNT_RST;
    assign bus_trig_out[2] = st_reg.trig2 != pss_pkg::CNT_RST;
    // clock led shows the synchronised level even while frozen
    assign master_trig_out = st_reg.trigm != 0;
    assign clock_led_out   = clk_lvl;
    assign random_led_out  = st_reg.cmp;

endmodule : pss_sequencer

`default_nettype wire

// ### testbench/pattern_shift_sequencer_tb.sv
// Purpose: self-checking bench for the pattern sequencer
// Assumes: short trigger and debounce counts
// Notes  : expected stages come from a local ring model
`timescale 1ns/1ps
`default_nettype none
module pattern_shift_sequencer_tb;
    logic        clk, rst, cmp, split, inv, en, b1, xle, rnd, mg, mt, xc, xl, lb, sb, rled, cled;
    logic [2:0]  mrg;
    logic [2:0]  gate;
    logic [2:0]  btrig;
    logic [15:0] sw;
    logic [15:0] mdl;
    logic [15:0] stage;
    logic [31:0] sel;
    int          errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    pss_panel u_pss_panel (.ref_clk_in(clk), .ext_clock_out(xc), .ext_load_out(xl),
        .load_button_out(lb), .step_button_out(sb));
    pss_sequencer #(.TRIG_COUNT(20), .DEB_COUNT(4)) u_pss_sequencer (.ref_clk_in(clk),
        .rst_in(rst), .ext_clock_in(xc), .ext_load_in(xl), .random_cmp_in(cmp),
        .load_button_in(lb), .step_button_in(sb), .pattern_switch_in(sw),
        .bus_select_in(sel), .merge_enable_in(mrg), .split_ring_select_in(split),
        .invert_second_in(inv), .clock_enable_in(en), .bus1_reload_in(b1),
        .ext_load_enable_in(xle), .random_mode_in(rnd), .stage_out(stage),
        .bus_gate_out(gate), .master_gate_out(mg), .bus_trig_out(btrig), .master_trig_out(mt),
        .clock_led_out(cled), .random_led_out(rled));
    // ==========================================================
    // 200 MHz clock and a cycle ceiling against hangs
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    function automatic logic [15:0] nxt(input logic [15:0] s);
        logic [15:0] n;
        n = {s[14:0], 1'h0};
        n[0] = rnd ? cmp : (split ? s[7] : s[15]);
        if (split)
            n[8] = s[15] ^ inv;
        for (int i = 0; i < 16; i++)
            if (b1 && n[i] && sel[2*i+:2] == 2'h0)
                return sw;
        return n;
    endfunction : nxt
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one clock pulse; outputs {trig, master, buses}, 5'h1f skips
    task automatic tick(input logic [4:0] hi, input logic [4:0] lo);
        u_pss_panel.pulse(0, 8, 0);
        if (hi != 5'h1f)
            chk({11'h0, mt, mg, gate}, {11'h0, hi}, "gates high");
        chk({15'h0, cled}, 16'h1, "clock led high");
        if (hi != 5'h1f && mrg == 3'h0)
            chk({13'h0, btrig}, {13'h0, hi[2:0]}, "bus trig high");
        if (en)
            mdl = nxt(mdl);
        repeat (24) @(negedge clk);
        if (hi != 5'h1f)
            chk({11'h0, mt, mg, gate}, {11'h0, lo}, "gates low");
        chk({15'h0, cled}, 16'h0, "clock led low");
        if (hi != 5'h1f)
            chk({13'h0, btrig}, 16'h0, "bus trig low");
        chk(stage, mdl, "stage");
    endtask : tick
    task automatic ld(input logic [15:0] p);
        sw = p;
        u_pss_panel.pulse(2, 10, 10);
        mdl = p;
        chk(stage, p, "load");
    endtask : ld
    task automatic end_of_test();
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // main sequence
    initial
    begin
        {clk, rst, cmp, split, inv, en, b1, xle, rnd} = 9'h088;
        {mrg, sw, mdl, sel} = {3'h0, 32'h0, 32'h5555_5555};
        repeat (3) @(negedge clk);
        rst = 1'h0;
        chk(stage, 16'h0, "reset");
        ld(16'ha5c3);
        ld(16'h0001);
        repeat (17) tick(5'h1a, 5'h00);
        for (int b = 0; b < 3; b++)
        begin
            sel = {16{b[1:0]}};
            mrg = 3'h0;
            tick({2'h3, 3'h1 << b}, 5'h00);
            mrg = 3'h1 << b;
            repeat (2) tick({2'h3, 3'h1 << b}, {2'h0, 3'h1 << b});
        end
        {mrg, sel, en} = {3'h0, 32'h5555_5555, 1'h0};
        tick(5'h00, 5'h00);
        repeat (2)
        begin
            u_pss_panel.pulse(3, 10, 10);
            mdl = nxt(mdl);
            chk(stage, mdl, "step");
        end
        {en, split} = 2'h3;
        ld(16'h0101);
        repeat (9) tick(5'h1a, 5'h00);
        inv = 1'h1;
        ld(16'h0100);
        repeat (17) tick(5'h1f, 5'h1f);
        {inv, split, b1, sel} = {3'h1, 32'h5555_5455};
        ld(16'h0001);
        repeat (8) tick(5'h1a, 5'h00);
        {b1, xle, sel} = {2'h1, 32'h5555_5555};
        repeat (3) tick(5'h1a, 5'h00);
        u_pss_panel.pulse(1, 10, 10);
        chk(stage, sw, "ext load");
        mdl = sw;
        xle = 1'h0;
        tick(5'h1a, 5'h00);
        u_pss_panel.pulse(1, 10, 10);
        chk(stage, mdl, "ext load off");
        {rnd, cmp} = 2'h3;
        tick(5'h1f, 5'h1f);
        chk({15'h0, rled}, 16'h1, "random led");
        cmp = 1'h0;
        repeat (17) tick(5'h1f, 5'h1f);
        {rnd, rst} = 2'h1;
        repeat (3) @(negedge clk);
        rst = 1'h0;
        chk(stage, 16'h0, "second reset");
        end_of_test();
    end
endmodule : pattern_shift_sequencer_tb
`default_nettype wire

// ### testbench/pss_panel.sv
// Purpose: front panel buttons and jack pulses
// Assumes: pins move on falling edges only
// Notes  : presses outlast the debounce window
`timescale 1ns/1ps
`default_nettype none
module pss_panel (
    input  wire logic ref_clk_in,
    output logic      ext_clock_out,
    output logic      ext_load_out,
    output logic      load_button_out,
    output logic      step_button_out
);
    // ==========================================================
    // one pin high for hi cycles, then low for lo cycles
    logic [3:0] pin_reg = 4'h0;
    assign {step_button_out, load_button_out, ext_load_out, ext_clock_out} = pin_reg;
    task automatic pulse(input int pin, input int hi, input int lo);
        @(negedge ref_clk_in) pin_reg[pin] = 1'h1;
        repeat (hi) @(negedge ref_clk_in);
        pin_reg[pin] = 1'h0;
        repeat (lo) @(negedge ref_clk_in);
    endtask : pulse
endmodule : pss_panel
`default_nettype wire

// ### testbench/pss_sequencer_props.sv
// Purpose: port checks for the pattern shift sequencer
// Assumes: short trigger count in simulation
// Notes  : bound onto every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module pss_seq_props #(
    parameter int TRIG_COUNT = 20
) (
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic        ext_clock_in,
    input wire logic        load_button_in,
    input wire logic        step_button_in,
    input wire logic        random_cmp_in,
    input wire logic        random_mode_in,
    input wire logic        split_ring_select_in,
    input wire logic        clock_enable_in,
    input wire logic        bus1_reload_in,
    input wire logic        ext_load_enable_in,
    input wire logic [2:0]  merge_enable_in,
    input wire logic [15:0] stage_out,
    input wire logic [2:0]  bus_gate_out,
    input wire logic        master_gate_out,
    input wire logic        master_trig_out,
    input wire logic        random_led_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ==========================================================
    // helpers: age since reset, trigger high count, last stages
    logic [7:0]  up_reg;
    logic [7:0]  hi_reg;
    logic [15:0] prev_reg;
    always_ff @(posedge ref_clk_in)
    begin
        up_reg   <= rst_in ? 8'h00 : up_reg + {7'h00, up_reg != 8'hff};
        hi_reg   <= (rst_in || !master_trig_out) ? 8'h00 : hi_reg + 8'h01;
        prev_reg <= stage_out;
    end
    // ==========================================================
    // quiet_s: no load, step or clock acts; plain_s: no load, random mode or bus-1 reload
    sequence quiet_s;
        (!clock_enable_in && !load_button_in && !step_button_in && !ext_load_enable_in)[*8];
    endsequence
    sequence plain_s;
        (!load_button_in && !ext_load_enable_in && !random_mode_in && !bus1_reload_in)[*8];
    endsequence
    freeze_hold_a: assert property (quiet_s |=> $stable(stage_out))
        else $error("stages moved while frozen");
    ring_rot_a: assert property (plain_s ##0 (!split_ring_select_in && $changed(stage_out))
        |-> stage_out == {prev_reg[14:0], prev_reg[15]}) else $error("ring step wrong");
    led_follow_a: assert property ($stable(random_cmp_in)[*5] ##0 (up_reg > 8'h06)
        |-> random_led_out == random_cmp_in) else $error("random led lost comparator");
    trig_width_a: assert property ($fell(master_trig_out) |-> hi_reg == TRIG_COUNT)
        else $error("trigger width wrong");
    trig_start_a: assert property ($rose(master_gate_out) |-> master_trig_out)
        else $error("no trigger at gate start");
    disabled_gate_a: assert property (!clock_enable_in[*4] |-> !master_gate_out)
        else $error("master gate while disabled");
    master_low_a: assert property (!ext_clock_in[*6] |-> !master_gate_out)
        else $error("master gate outlived clock");
    bus_low_a: assert property ((!ext_clock_in && merge_enable_in == 3'h0)[*6]
        |-> bus_gate_out == 3'h0) else $error("unmerged bus gate held");
endmodule : pss_seq_props
bind pss_sequencer pss_seq_props #(.TRIG_COUNT(TRIG_COUNT)) u_props (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ext_clock_in(ext_clock_in),
    .load_button_in(load_button_in), .step_button_in(step_button_in),
    .random_cmp_in(random_cmp_in), .random_mode_in(random_mode_in),
    .split_ring_select_in(split_ring_select_in), .clock_enable_in(clock_enable_in),
    .bus1_reload_in(bus1_reload_in), .ext_load_enable_in(ext_load_enable_in),
    .merge_enable_in(merge_enable_in), .stage_out(stage_out), .bus_gate_out(bus_gate_out),
    .master_gate_out(master_gate_out), .master_trig_out(master_trig_out),
    .random_led_out(random_led_out));
`default_nettype wire
